// *** hw/tkps_pkg.sv ***
// tkps_pkg: constants and types for the trip keying and power select block
package tkps_pkg;

	// --------------------------------------------------------------
	// keying modes and power levels
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		KEY_SINGLE,
		KEY_REDUNDANT,
		KEY_START_STOP,
		KEY_THREE_FREQ
	} tkps_key_e;

	typedef enum logic [1:0] {
		PWR_LOW,
		PWR_MID,
		PWR_HIGH
	} tkps_pwr_e;

	// switch pair {a, b}: 1,1 = 1 W; 1,0 = 3 W; 0,x = 10 W (b driven 1)
	localparam logic [1:0] SW_LOW  = 2'h3;
	localparam logic [1:0] SW_MID  = 2'h2;
	localparam logic [1:0] SW_HIGH = 2'h1;

	// --------------------------------------------------------------
	// input pin bit positions in the synchroniser vector
	// --------------------------------------------------------------
	localparam int IN_TRIP1 = 0;
	localparam int IN_TRIP2 = 1;
	localparam int IN_VOICE = 2;
	localparam int IN_BOOST = 3;
	localparam int IN_DROP  = 4;
	localparam int IN_PICK  = 5;
	localparam int IN_W     = 6;

	// --------------------------------------------------------------
	// jumper configuration and transmitter control word
	// --------------------------------------------------------------
	typedef struct packed {
		tkps_key_e key_mode;
		logic      voice_system;
		logic      mute_on_trip;
		tkps_pwr_e guard_level;
		tkps_pwr_e trip_level;
	} tkps_cfg_s;

	typedef struct packed {
		logic freq_sel_one;
		logic freq_sel_two;
		logic switch_a;
		logic switch_b;
		logic speech_am_gate;
	} tkps_tx_s;

	localparam tkps_tx_s TX_RESET = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

endpackage

// *** hw/tkps_keying.sv ***
// tkps_keying: trip input keying, frequency and power selection, alarm
`timescale 1ns/1ps

module tkps_keying
	import tkps_pkg::*;
#(
	parameter int SYNC_DEPTH = 2
) (
	input  wire logic      clock,
	input  wire logic      reset,
	input  wire tkps_cfg_s cfg,
	input  wire logic      trip_one,
	input  wire logic      trip_two,
	input  wire logic      voice_enable,
	input  wire logic      force_boost,
	input  wire logic      carrier_above_drop,
	input  wire logic      carrier_above_pick,
	output tkps_tx_s       tx_ctrl,
	output logic           trip_one_indicator,
	output logic           trip_two_indicator,
	output logic           carrier_level_indicator,
	output logic           has_tripped_n
);

	// --------------------------------------------------------------
	// elaboration checks
	// --------------------------------------------------------------
	if (SYNC_DEPTH != 2) begin : g_bad_depth
		$error("tkps_keying: SYNC_DEPTH must be 2");
	end

	// --------------------------------------------------------------
	// input synchronisers
	// --------------------------------------------------------------
	// trip contacts arrive through isolators, asynchronous to clock
	logic [IN_W-1:0] sync_a;
	logic [IN_W-1:0] sync_b;
	tkps_cfg_s       cfg_a;
	tkps_cfg_s       cfg_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {carrier_above_pick, carrier_above_drop,
				force_boost, voice_enable, trip_two, trip_one};
			sync_b <= sync_a;
		end
	end

	// jumpers are static straps; double registered all the same
	always_ff @(posedge clock) begin
		cfg_a <= cfg;
		cfg_q <= cfg_a;
	end

	logic t1;
	logic t2;
	logic voice;
	logic boost;
	logic tripping;

	assign t1       = sync_b[IN_TRIP1];
	assign t2       = sync_b[IN_TRIP2];
	assign voice    = sync_b[IN_VOICE];
	assign boost    = sync_b[IN_BOOST];
	assign tripping = t1 | t2;

	// --------------------------------------------------------------
	// frequency selection
	// --------------------------------------------------------------
	logic next_sel_one;
	logic next_sel_two;

	// no register between the synchronisers and the output stage
	always_comb begin
		next_sel_one = 1'b0;
		next_sel_two = 1'b1;
		case (cfg_q.key_mode)
			KEY_SINGLE: begin
				next_sel_one = t1;
			end
			KEY_REDUNDANT: begin
				next_sel_one = t1 & t2;
			end
			KEY_START_STOP: begin
				next_sel_one = t1 & ~t2;
			end
			KEY_THREE_FREQ: begin
				// first select is a don't care while the second is low
				next_sel_one = t1;
				next_sel_two = ~t2;
			end
			default: begin
				next_sel_one = 1'b0;
				next_sel_two = 1'b1;
			end
		endcase
	end

	// --------------------------------------------------------------
	// power level and modulator gate
	// --------------------------------------------------------------
	tkps_pwr_e base_level;
	tkps_pwr_e level;
	logic      muted;
	logic      voice_on;
	logic      next_gate;
	logic [1:0] next_sw;

	always_comb begin
		base_level = tripping ? cfg_q.trip_level : cfg_q.guard_level;
		muted      = cfg_q.mute_on_trip & tripping;
		voice_on   = cfg_q.voice_system & voice & ~muted;
		level      = base_level;
		next_gate  = 1'b0;
		// boost is assumed absent in voice systems, so it simply wins
		if (boost) begin
			level     = PWR_HIGH;
			next_gate = 1'b0;
		end else if (voice_on) begin
			// speech always rides at the middle level
			level     = PWR_MID;
			next_gate = 1'b1;
		end
		case (level)
			PWR_LOW:  next_sw = SW_LOW;
			PWR_MID:  next_sw = SW_MID;
			PWR_HIGH: next_sw = SW_HIGH;
			default:  next_sw = SW_LOW;
		endcase
		if (level == PWR_HIGH) begin
			next_gate = 1'b0;
		end
	end

	tkps_tx_s next_tx;

	always_comb begin
		next_tx.freq_sel_one   = next_sel_one;
		next_tx.freq_sel_two   = next_sel_two;
		next_tx.switch_a       = next_sw[1];
		next_tx.switch_b       = next_sw[0];
		next_tx.speech_am_gate = next_gate;
	end

	// --------------------------------------------------------------
	// indicators, status and carrier alarm
	// --------------------------------------------------------------
	logic next_ind_one;
	logic next_ind_two;
	logic next_has_tripped_n;
	logic next_alarm;

	always_comb begin
		next_ind_one       = t1;
		next_ind_two       = t2;
		next_has_tripped_n = ~tripping;
		next_alarm         = carrier_level_indicator;
		// gap between drop and pick levels gives the hysteresis
		if (!sync_b[IN_DROP]) begin
			next_alarm = 1'b0;
		end else if (sync_b[IN_PICK]) begin
			next_alarm = 1'b1;
		end
	end

	// --------------------------------------------------------------
	// output registers
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			tx_ctrl                 <= TX_RESET;
			trip_one_indicator      <= 1'b0;
			trip_two_indicator      <= 1'b0;
			carrier_level_indicator <= 1'b0;
			has_tripped_n           <= 1'b1;
		end else begin
			tx_ctrl                 <= next_tx;
			trip_one_indicator      <= next_ind_one;
			trip_two_indicator      <= next_ind_two;
			carrier_level_indicator <= next_alarm;
			has_tripped_n           <= next_has_tripped_n;
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	a_guard_sends: assert property (
		@(posedge clock) disable iff (reset)
		(!t1 && !t2) |=> (!tx_ctrl.freq_sel_one && tx_ctrl.freq_sel_two
			&& has_tripped_n)
	) else $error("guard not sent with no trip input");

	a_trip_indicators: assert property (
		@(posedge clock) disable iff (reset)
		##1 ((trip_one_indicator == $past(t1))
			&& (trip_two_indicator == $past(t2)))
	) else $error("trip indicator does not follow its input");

	a_single_mode: assert property (
		@(posedge clock) disable iff (reset)
		(cfg_q.key_mode == KEY_SINGLE)
			|=> tx_ctrl.freq_sel_one == $past(t1)
	) else $error("single mode select differs from trip one");

	a_redundant_mode: assert property (
		@(posedge clock) disable iff (reset)
		(cfg_q.key_mode == KEY_REDUNDANT)
			|=> tx_ctrl.freq_sel_one == ($past(t1) && $past(t2))
	) else $error("redundant mode select wrong");

	a_start_stop: assert property (
		@(posedge clock) disable iff (reset)
		(cfg_q.key_mode == KEY_START_STOP && t2)
			|=> !tx_ctrl.freq_sel_one
	) else $error("trip two did not cancel trip one");

	a_three_freq: assert property (
		@(posedge clock) disable iff (reset)
		(cfg_q.key_mode == KEY_THREE_FREQ)
			|=> (tx_ctrl.freq_sel_two == !$past(t2))
	) else $error("three frequency second select wrong");

	a_force_boost: assert property (
		@(posedge clock) disable iff (reset)
		boost |=> (!tx_ctrl.switch_a && !tx_ctrl.speech_am_gate)
	) else $error("force boost did not command highest level");

	a_gate_level: assert property (
		@(posedge clock) disable iff (reset)
		tx_ctrl.speech_am_gate |-> (tx_ctrl.switch_a && !tx_ctrl.switch_b)
	) else $error("modulator gated outside middle level");

	a_voice_mid: assert property (
		@(posedge clock) disable iff (reset)
		(!boost && voice && cfg_q.voice_system && !cfg_q.mute_on_trip)
			|=> tx_ctrl.speech_am_gate
	) else $error("unmuted voice did not enable modulator");

	a_has_tripped: assert property (
		@(posedge clock) disable iff (reset)
		(t1 || t2) |=> !has_tripped_n
	) else $error("has-tripped not low during trip");

	a_alarm_drop: assert property (
		@(posedge clock) disable iff (reset)
		!sync_b[IN_DROP] |=> !carrier_level_indicator
	) else $error("carrier alarm did not drop out");

	a_alarm_hold: assert property (
		@(posedge clock) disable iff (reset)
		(carrier_level_indicator && sync_b[IN_DROP])
			|=> carrier_level_indicator
	) else $error("carrier alarm dropped above drop level");

	a_trip_boost: assert property (
		@(posedge clock) disable iff (reset)
		(!boost && !cfg_q.voice_system && t1
			&& cfg_q.trip_level == PWR_HIGH) |=> !tx_ctrl.switch_a
	) else $error("trip did not raise level to highest");

	a_guard_low: assert property (
		@(posedge clock) disable iff (reset)
		(!boost && !voice_on && !tripping && cfg_q.guard_level == PWR_LOW)
			|=> (tx_ctrl.switch_a && tx_ctrl.switch_b)
	) else $error("guard did not command lowest level");

	a_three_freq_one: assert property (
		@(posedge clock) disable iff (reset)
		(cfg_q.key_mode == KEY_THREE_FREQ && !t2)
			|=> (tx_ctrl.freq_sel_one == $past(t1))
	) else $error("three frequency first select wrong");

	a_high_no_gate: assert property (
		@(posedge clock) disable iff (reset)
		!tx_ctrl.switch_a |-> !tx_ctrl.speech_am_gate
	) else $error("modulator gated at highest level");

	a_muted_gate: assert property (
		@(posedge clock) disable iff (reset)
		(tripping && cfg_q.mute_on_trip) |=> !tx_ctrl.speech_am_gate
	) else $error("muted voice still gates modulator");

endmodule

// *** sim/tkps_far_side.sv ***
// tkps_far_side: trip contacts, speech card and carrier comparators
`timescale 1ns/1ps

module tkps_far_side (
	input  wire logic       clock,
	input  wire logic       voice_system,
	input  wire logic [5:0] want,
	output logic            trip_one,
	output logic            trip_two,
	output logic            voice_enable,
	output logic            force_boost,
	output logic            carrier_above_drop,
	output logic            carrier_above_pick
);
	// ----------------------------------------------------------
	// pin levels, moved just after an edge
	// ----------------------------------------------------------
	// levels are unknown only until the first edge, inside reset
	always @(posedge clock) begin
		trip_one           <= want[0];
		trip_two           <= want[1];
		voice_enable       <= want[2];
		// boost kept off where speech may be carried
		force_boost        <= want[3] & ~voice_system;
		carrier_above_drop <= want[4];
		// pick threshold sits above drop, so it never leads
		carrier_above_pick <= want[5] & want[4];
	end
endmodule

// *** sim/test_trip_keying_power_select.sv ***
// test_trip_keying_power_select: self-checking bench for tkps_keying
`timescale 1ns/1ps

module test_trip_keying_power_select;
	import tkps_pkg::*;

	logic       clock = 1'b0;
	logic       reset = 1'b1;
	tkps_cfg_s  cfg   = '0;
	logic [5:0] want  = 6'h00;
	logic       t1, t2, ve, fb, ad, ap;
	tkps_tx_s   tx;
	logic       ind1, ind2, alm, htn;
	logic [8:0] q[$];
	logic [8:0] e;
	logic       alm_m = 1'b0;
	int         n_fail = 0;
	int         checks = 0;
	int         seed   = 2555;

	always #4 clock = ~clock;

	tkps_far_side i_far (.clock(clock), .voice_system(cfg.voice_system), .want(want),
		.trip_one(t1), .trip_two(t2), .voice_enable(ve), .force_boost(fb),
		.carrier_above_drop(ad), .carrier_above_pick(ap));

	tkps_keying #(.SYNC_DEPTH(2)) i_dut (.clock(clock), .reset(reset), .cfg(cfg),
		.trip_one(t1), .trip_two(t2), .voice_enable(ve), .force_boost(fb),
		.carrier_above_drop(ad), .carrier_above_pick(ap), .tx_ctrl(tx),
		.trip_one_indicator(ind1), .trip_two_indicator(ind2),
		.carrier_level_indicator(alm), .has_tripped_n(htn));

	// ----------------------------------------------------------
	// compare, verdict and stimulus tasks
	// ----------------------------------------------------------
	task automatic check(input string name, input logic [4:0] exp, input logic [4:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic finish_test;
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic apply(input tkps_cfg_s c, input logic [5:0] w);
		tkps_pwr_e  lv;
		logic       t, von, b, s1;
		logic [1:0] sw;
		t   = w[0] | w[1];
		b   = w[3] & ~c.voice_system;
		von = c.voice_system & w[2] & ~(c.mute_on_trip & t);
		lv  = b ? PWR_HIGH : von ? PWR_MID : t ? c.trip_level : c.guard_level;
		sw  = (lv == PWR_HIGH) ? SW_HIGH : (lv == PWR_MID) ? SW_MID : SW_LOW;
		case (c.key_mode)
			KEY_REDUNDANT:  s1 = w[0] & w[1];
			KEY_START_STOP: s1 = w[0] & ~w[1];
			default:        s1 = w[0];
		endcase
		if (!w[4])
			alm_m = 1'b0;
		else if (w[5])
			alm_m = 1'b1;
		@(posedge clock);
		cfg  <= c;
		want <= w;
		q.push_back({s1, ~(c.key_mode == KEY_THREE_FREQ && w[1]), sw, ~b & von,
			w[0], w[1], alm_m, ~t});
		repeat (5) @(posedge clock);
	endtask

	// ----------------------------------------------------------
	// output watcher: oldest note against settled outputs
	// ----------------------------------------------------------
	initial forever begin
		wait (q.size() > 0);
		repeat (5) @(posedge clock);
		#1;
		e = q.pop_front();
		check("freq select", {3'h0, e[8:7]}, {3'h0, tx.freq_sel_one, tx.freq_sel_two});
		check("power switch", {3'h0, e[6:5]}, {3'h0, tx.switch_a, tx.switch_b});
		check("speech gate", {4'h0, e[4]}, {4'h0, tx.speech_am_gate});
		check("indicators", {3'h0, e[3:2]}, {3'h0, ind1, ind2});
		check("carrier alarm", {4'h0, e[1]}, {4'h0, alm});
		check("has tripped", {4'h0, e[0]}, {4'h0, htn});
	end

	initial begin
		repeat (10000) @(posedge clock);
		n_fail++;
		finish_test();
	end

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		logic [31:0] r;
		tkps_cfg_s   c;
		repeat (5) @(posedge clock);
		#1;
		check("reset word", TX_RESET, tx);
		check("reset status", 5'h01, {1'b0, ind1, ind2, alm, htn});
		@(posedge clock);
		reset <= 1'b0;
		// every mode against every trip pair, boost config, no voice, carrier up
		for (int m = 0; m < 16; m++) begin
			c = {m[3:2], 2'h0, PWR_LOW, PWR_HIGH};
			apply(c, {4'hC, m[1:0]});
		end
		// random jumpers and pins; hysteresis gets hold cases too
		repeat (300) begin
			r = $random(seed);
			c = r[7:0];
			if (c.guard_level == 2'h3)
				c.guard_level = PWR_MID;
			if (c.trip_level == 2'h3)
				c.trip_level = PWR_LOW;
			apply(c, r[13:8]);
		end
		wait (q.size() == 0);
		repeat (6) @(posedge clock);
		finish_test();
	end
endmodule
